// file: hdl/ilpa_pkg.sv
// Purpose: constants, register indices and carrier types for the level/priority/ack block
// Assumes: Avalon-MM word indices; byte address is four times the index
// Notes:   one controller instance with 63 request sources
// ****************************************************************
// package
// ****************************************************************
package ilpa_pkg;
    // source counts
    localparam int          NUM_SRC        = 64;       // index 0 is never a source
    localparam int          FIXED_LAST     = 7;        // sources 1..7 have fixed levels
    localparam int          NUM_FLAGS      = 13;       // locally held sticky flags
    // register word indices
    localparam logic [7:0]  IDX_ACK_LP     = 8'h00;
    localparam logic [7:0]  IDX_LVL_REQ    = 8'h01;
    localparam logic [7:0]  IDX_MASK_HI    = 8'h02;
    localparam logic [7:0]  IDX_MASK_LO    = 8'h03;
    localparam logic [7:0]  IDX_PEND_HI    = 8'h04;
    localparam logic [7:0]  IDX_PEND_LO    = 8'h05;
    localparam logic [7:0]  IDX_FLAG_STAT  = 8'h06;
    localparam logic [7:0]  IDX_FLAG_CLR   = 8'h07;
    localparam logic [7:0]  IDX_FLAG_EN    = 8'h08;
    localparam logic [7:0]  IDX_PIT_MOD    = 8'h09;
    localparam logic [1:0]  IDX_CTRL_PAGE  = 2'h1;     // indices 0x40..0x7f: per-source ctrl
    // reset values
    localparam logic [63:0] MASK_RESET     = 64'hffff_ffff_ffff_ffff;
    localparam logic [5:0]  CTRL_RESET     = 6'h00;    // level 0 means disabled
    localparam logic [12:0] FLAG_RESET     = 13'h0000;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
    // priority codes and ranking keys
    localparam logic [3:0]  PRIO_MIDPOINT  = 4'h8;     // reported for fixed-level sources
    localparam logic [3:0]  KEY_MIDPOINT   = 4'h4;     // ranks between codes 3 and 4
    localparam logic [2:0]  PRIO_SPLIT     = 3'h4;
    // flag positions inside the sticky flag register
    localparam int          FLG_DMA        = 0;
    localparam int          FLG_QSER       = 4;
    localparam int          FLG_GPT        = 5;
    localparam int          FLG_PIT        = 9;
    // source numbers
    localparam int          SRC_WDOG       = 8;
    localparam int          SRC_DMA        = 9;
    localparam int          SRC_UNUSED     = 16;
    localparam int          SRC_QSER       = 18;
    localparam int          SRC_GPT        = 19;
    localparam int          SRC_PIT        = 36;
    // per-source control byte
    typedef struct packed {
        logic [1:0] rsv;
        logic [2:0] level;
        logic [2:0] prio;
    } ilpa_ctrl_t;
    // acknowledge level/priority byte
    typedef struct packed {
        logic       rsv;
        logic [2:0] level;
        logic [3:0] prio;
    } ilpa_ack_lp_t;
endpackage

// file: hdl/ilpa_top.sv
// Purpose: level/priority assignment and acknowledge handling of one interrupt controller
// Assumes: all inputs synchronous to CLK_SYS_IN; ack requests are one-cycle pulses
// Notes:   sticky flags of the watched peripheral sources are held here, with a level irq
//
// Overview of operation
// - ack returns vector of best pending source
// - ack answers vector; loads level/priority byte only if a source is found
// - ack byte read-only: rsv, level, priority
// - priority codes 0-7, 8 is midpoint
// - ctrl byte: level 5-3, priority 2-0
// - ctrl readable; only sources 8-63 writable
// - reset ctrl value means source disabled
// - priority 000 lowest, 111 highest
// - fixed sources use midpoint, read 000
// - source 8 is self-clearing watchdog timeout
// - sources 9-12 DMA done, write-one clears
// - source 18 queued serial, write-one clears
// - sources 19-22 timers, write-one clears
// - sources 36-39 periodic flags, two clears
// - per-level request bits, updated every cycle
// - mask bit one blocks request, pending raw
`timescale 1ns/100ps
module ilpa_top
    import ilpa_pkg::*;
#(
    parameter logic [7:0] VECTOR_BASE     = 8'h40,   // vector of source n is base plus n
    parameter logic [7:0] SPURIOUS_VECTOR = 8'h18    // answer when nothing qualifies
)(
    // clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_N_IN,
    // avalon-mm slave
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // request sources
    input  wire logic [63:0] SRC_REQ_IN,
    input  wire logic        WDOG_TIMEOUT_IN,
    input  wire logic [3:0]  DMA_DONE_EVT_IN,
    input  wire logic        QSER_EVT_IN,
    input  wire logic [3:0]  GPT_EVT_IN,
    input  wire logic [3:0]  PIT_EVT_IN,
    // acknowledge port
    input  wire logic        INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN,
    input  wire logic [2:0]  INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN,
    output logic      [7:0]  INTERRUPT_ACKNOWLEDGE_CYCLE_VECTOR_OUT,
    output logic             INTERRUPT_ACKNOWLEDGE_CYCLE_DONE_OUT,
    // request outputs
    output logic      [7:0]  LEVEL_REQ_OUT,
    output logic             IRQ_OUT
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (int'(VECTOR_BASE) + NUM_SRC - 1 > 255)
    begin : g_bad_base
        $error("vector base leaves no room for 63 sources");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic               waitreq;                 // bus wait flop, high while idle
    logic [31:0]        rdata;                   // registered read data
    logic [63:0]        mask;                    // source mask, bit 0 is mask-all
    logic [12:0]        flag;                    // sticky peripheral flags
    logic [12:0]        flag_en;                 // flag interrupt enables
    ilpa_ack_lp_t       ack_lp;                  // acknowledged level/priority
    logic [7:0]         interrupt_acknowledge_cycle_vec;                // acknowledge vector flop
    logic               interrupt_acknowledge_cycle_done;               // acknowledge answer pulse
    logic [7:0]         lvl_req;                 // per-level request flop
    logic               irq;                     // interrupt output flop
    logic [5:0]         ctrl_rd [NUM_SRC];       // per-source ctrl as read
    logic [3:0]         key     [NUM_SRC];       // ranking key per source
    logic [NUM_SRC-1:0] elig;                    // candidates for this ack
    logic [7:0]         lvl_hot [NUM_SRC];       // one-hot level per active source
    logic [63:0]        req_raw;                 // raw request per source
    logic [63:0]        eff_mask;                // mask after mask-all
    logic [63:0]        active;                  // unmasked pending sources
    logic [7:0]         next_lvl_req;
    logic [12:0]        next_flag;
    logic [5:0]         best_src;
    logic [3:0]         best_key;
    logic               found;
    logic [31:0]        rd_mux;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire        bus_req   = AVS_READ_IN | AVS_WRITE_IN;
    wire        acc       = bus_req & ~waitreq;          // edge at which access completes
    wire        wr_acc    = acc & AVS_WRITE_IN;
    wire        ctrl_hit  = (AVS_ADDRESS_IN[7:6] == IDX_CTRL_PAGE);
    wire [5:0]  ctrl_sel  = AVS_ADDRESS_IN[5:0];
    wire        wr_mhi    = wr_acc & (AVS_ADDRESS_IN == IDX_MASK_HI);
    wire        wr_mlo    = wr_acc & (AVS_ADDRESS_IN == IDX_MASK_LO);
    wire        wr_fclr   = wr_acc & (AVS_ADDRESS_IN == IDX_FLAG_CLR);
    wire        wr_fen    = wr_acc & (AVS_ADDRESS_IN == IDX_FLAG_EN);
    wire        wr_pmod   = wr_acc & (AVS_ADDRESS_IN == IDX_PIT_MOD);

    // byte-lane merge for the wide registers
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // request sources
    // ****************************************************************
    // flag sources replace their raw lines; the peripheral only pulses events
    always_comb
    begin
        req_raw                   = SRC_REQ_IN;
        req_raw[0]                = 1'b0;                       // no source zero
        req_raw[SRC_WDOG]         = WDOG_TIMEOUT_IN;
        req_raw[SRC_DMA  +: 4]    = flag[FLG_DMA +: 4];
        req_raw[SRC_QSER]         = flag[FLG_QSER];
        req_raw[SRC_GPT  +: 4]    = flag[FLG_GPT +: 4];
        req_raw[SRC_PIT  +: 4]    = flag[FLG_PIT +: 4];
        req_raw[SRC_UNUSED]       = 1'b0;
    end

    // mask-all forces every source masked without touching the stored bits
    assign eff_mask = mask | {64{mask[0]}};
    assign active   = req_raw & ~eff_mask;

    // sticky flags: an event in the clearing cycle wins over the clear
    wire [12:0] flag_evt = {PIT_EVT_IN, GPT_EVT_IN, QSER_EVT_IN, DMA_DONE_EVT_IN};
    wire [12:0] flag_clr = (wr_fclr ? AVS_WRITEDATA_IN[12:0] : 13'h0000)
                         | (wr_pmod ? {AVS_WRITEDATA_IN[3:0], 9'h000} : 13'h0000);
    assign next_flag = (flag & ~flag_clr) | flag_evt;

    // ****************************************************************
    // per-source control and ranking
    // ****************************************************************
    genvar s;
    for (s = 0; s < NUM_SRC; s++)
    begin : g_src
        if (s <= FIXED_LAST)
        begin : g_fixed
            // fixed sources sit at their own level and read priority 000
            assign ctrl_rd[s] = {3'(s), 3'h0};
            assign key[s]     = KEY_MIDPOINT;
        end
        else
        begin : g_prog
            logic [5:0] ctrl;                                   // level and priority bits
            wire        wr_me = wr_acc & ctrl_hit & (ctrl_sel == 6'(s))
                              & AVS_BYTEENABLE_IN[0];
            // reserved bits 7..6 are not stored and read as zero
            always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
            begin
                if (!RST_N_IN)
                    ctrl <= CTRL_RESET;
                else if (wr_me)
                    ctrl <= AVS_WRITEDATA_IN[5:0];
            end
            assign ctrl_rd[s] = ctrl;
            // codes above 3 step past the midpoint slot
            assign key[s] = {1'b0, ctrl[2:0]}
                          + ((ctrl[2:0] >= PRIO_SPLIT) ? 4'h1 : 4'h0);
        end
        // a source at level 0 can neither request nor be acknowledged
        assign elig[s]    = active[s] & (ctrl_rd[s][5:3] == INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN)
                          & (ctrl_rd[s][5:3] != 3'h0);
        assign lvl_hot[s] = active[s] ? (8'h01 << ctrl_rd[s][5:3]) : 8'h00;
    end

    // highest key among candidates; unique pairs make ties impossible
    always_comb
    begin
        found    = 1'b0;
        best_key = 4'h0;
        best_src = 6'h00;
        for (int i = 1; i < NUM_SRC; i++)
        begin
            if (elig[i] && (!found || key[i] > best_key))
            begin
                found    = 1'b1;
                best_key = key[i];
                best_src = 6'(i);
            end
        end
    end

    // per-level request: level 0 is never driven
    always_comb
    begin
        next_lvl_req = 8'h00;
        for (int i = 1; i < NUM_SRC; i++)
        begin
            next_lvl_req = next_lvl_req | lvl_hot[i];
        end
        next_lvl_req[0] = 1'b0;
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    assign rd_mux = ctrl_hit                         ? {26'h0, ctrl_rd[ctrl_sel]} :
                    (AVS_ADDRESS_IN == IDX_ACK_LP)    ? {24'h0, ack_lp}          :
                    (AVS_ADDRESS_IN == IDX_LVL_REQ)   ? {24'h0, lvl_req}         :
                    (AVS_ADDRESS_IN == IDX_MASK_HI)   ? mask[63:32]              :
                    (AVS_ADDRESS_IN == IDX_MASK_LO)   ? mask[31:0]               :
                    (AVS_ADDRESS_IN == IDX_PEND_HI)   ? req_raw[63:32]           :
                    (AVS_ADDRESS_IN == IDX_PEND_LO)   ? req_raw[31:0]            :
                    (AVS_ADDRESS_IN == IDX_FLAG_STAT) ? {19'h0, flag}            :
                    (AVS_ADDRESS_IN == IDX_FLAG_EN)   ? {19'h0, flag_en}         :
                                                        READ_ZERO;  // unmapped, write-only

    // ****************************************************************
    // bus slave flops
    // ****************************************************************
    // one wait cycle per access; read data is caught on the wait cycle
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            waitreq <= 1'b1;
            rdata   <= READ_ZERO;
        end
        else
        begin
            waitreq <= ~(bus_req & waitreq);
            if (AVS_READ_IN && waitreq)
                rdata <= rd_mux;
        end
    end

    // mask, enables and flags
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            mask    <= MASK_RESET;
            flag    <= FLAG_RESET;
            flag_en <= FLAG_RESET;
        end
        else
        begin
            if (wr_mhi)
                mask[63:32] <= be_merge(mask[63:32], AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            if (wr_mlo)
                mask[31:0]  <= be_merge(mask[31:0], AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            if (wr_fen)
                flag_en     <= AVS_WRITEDATA_IN[12:0];
            flag <= next_flag;
        end
    end

    // ****************************************************************
    // acknowledge and request outputs
    // ****************************************************************
    // the ack byte only moves on an acknowledge that finds a source
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ack_lp    <= '0;
            interrupt_acknowledge_cycle_vec  <= 8'h00;
            interrupt_acknowledge_cycle_done <= 1'b0;
            lvl_req   <= 8'h00;
            irq       <= 1'b0;
        end
        else
        begin
            interrupt_acknowledge_cycle_done <= INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN;
            if (INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN)
                interrupt_acknowledge_cycle_vec <= found ? (VECTOR_BASE + {2'h0, best_src}) : SPURIOUS_VECTOR;
            if (INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN && found)
            begin
                ack_lp.rsv   <= 1'b0;
                ack_lp.level <= INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN;
                ack_lp.prio  <= (best_src <= 6'(FIXED_LAST)) ? PRIO_MIDPOINT
                                : {1'b0, ctrl_rd[best_src][2:0]};
            end
            lvl_req <= next_lvl_req;
            irq     <= |(next_flag & flag_en);
        end
    end

    assign AVS_READDATA_OUT    = rdata;
    assign AVS_WAITREQUEST_OUT = waitreq;
    assign INTERRUPT_ACKNOWLEDGE_CYCLE_VECTOR_OUT     = interrupt_acknowledge_cycle_vec;
    assign INTERRUPT_ACKNOWLEDGE_CYCLE_DONE_OUT       = interrupt_acknowledge_cycle_done;
    assign LEVEL_REQ_OUT       = lvl_req;
    assign IRQ_OUT             = irq;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_ack_found;
        INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN && found;
    endsequence
    sequence s_answer;
        ##1 interrupt_acknowledge_cycle_done;
    endsequence

    property p_ack_answer;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN |-> s_answer;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack not answered");

    property p_ack_vector;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_ack_found |=> interrupt_acknowledge_cycle_vec == VECTOR_BASE + {2'h0, $past(best_src)};
    endproperty
    a_ack_vector: assert property (p_ack_vector) else $error("wrong vector");

    property p_ack_level;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_ack_found |=> ack_lp.level == $past(INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN);
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("ack level not loaded");

    property p_ack_rsv;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        ack_lp.rsv == 1'b0 && ack_lp.prio <= PRIO_MIDPOINT;
    endproperty
    a_ack_rsv: assert property (p_ack_rsv) else $error("ack byte out of range");

    property p_ack_hold;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        !INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN |=> $stable(ack_lp);
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack byte moved");

    property p_level0_spurious;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN && INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN == 3'h0 |=> interrupt_acknowledge_cycle_vec == SPURIOUS_VECTOR;
    endproperty
    a_level0_spurious: assert property (p_level0_spurious) else $error("level 0 acked");

    property p_fixed_read;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        AVS_READ_IN && waitreq && ctrl_hit && ctrl_sel <= 6'(FIXED_LAST)
        |=> rdata[5:0] == {$past(ctrl_sel[2:0]), 3'h0};
    endproperty
    a_fixed_read: assert property (p_fixed_read) else $error("fixed ctrl misread");

    property p_mask_all;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        mask[0] |=> lvl_req == 8'h00;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked request seen");

    property p_dma_set;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        DMA_DONE_EVT_IN != 4'h0 |=> (flag[3:0] & $past(DMA_DONE_EVT_IN)) == $past(DMA_DONE_EVT_IN);
    endproperty
    a_dma_set: assert property (p_dma_set) else $error("dma event lost");

    property p_unused16;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        req_raw[SRC_UNUSED] == 1'b0;
    endproperty
    a_unused16: assert property (p_unused16) else $error("source 16 active");

endmodule // ilpa_top

// file: sim/ilpa_core_model.sv
// Purpose: processor core model that issues acknowledge cycles
// Assumes: one acknowledge at a time; request is a one-cycle pulse
// Notes:   level lines are scrambled when idle so stale values never match
`timescale 1ns/100ps
module ilpa_core_model
(
    // clock
    input  wire logic       clk_in,
    // answer from the controller
    input  wire logic [7:0] vec_in,
    input  wire logic       done_in,
    // request to the controller
    output logic            req_out,
    output logic [2:0]      lvl_out
);
    // ********************************
    // acknowledge cycle, optionally after idle cycles (a slow core)
    // ********************************
    task automatic ack(input logic [2:0] lvl, input int idle, output logic [7:0] vec);
        int n;
        repeat (idle) @(posedge clk_in);
        req_out <= 1'b1;
        lvl_out <= lvl;
        @(posedge clk_in);
        req_out <= 1'b0;
        lvl_out <= ~lvl;   // released lines do not keep the old level
        vec = 8'hxx;       // stays unknown if done never comes
        for (n = 0; n < 8; n++)
        begin
            @(posedge clk_in);
            if (done_in === 1'b1)
            begin
                vec = vec_in;
                break;
            end
        end
    endtask
    // idle state at time zero
    initial
    begin
        req_out = 1'b0;
        lvl_out = 3'h0;
    end
endmodule // ilpa_core_model

// file: sim/testbench.sv
// Purpose: self-checking bench for the level/priority/acknowledge block
// Assumes: one bus access at a time; byte enables on unless a test drops lane 0
// Notes:   expected values are worked out by hand from the control byte layout
`timescale 1ns/100ps
module testbench;
    import ilpa_pkg::*;
    logic        clk, rst_n, rd, wr, wq, dn, irq, wdg, qs;
    logic [7:0]  adr, vec, lrq, v;
    logic [31:0] wd, rdd, r;
    logic [63:0] src;
    logic [3:0]  dma, gpt, pit, be;
    logic        iq;
    logic [2:0]  il;
    int          n_errors, n_checks;
    // ********************************
    // design and core model
    // ********************************
    ilpa_top u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdd), .AVS_WAITREQUEST_OUT(wq),
        .SRC_REQ_IN(src), .WDOG_TIMEOUT_IN(wdg), .DMA_DONE_EVT_IN(dma), .QSER_EVT_IN(qs),
        .GPT_EVT_IN(gpt), .PIT_EVT_IN(pit), .INTERRUPT_ACKNOWLEDGE_CYCLE_REQ_IN(iq), .INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_IN(il),
        .INTERRUPT_ACKNOWLEDGE_CYCLE_VECTOR_OUT(vec), .INTERRUPT_ACKNOWLEDGE_CYCLE_DONE_OUT(dn), .LEVEL_REQ_OUT(lrq), .IRQ_OUT(irq));
    ilpa_core_model u_core (.clk_in(clk), .vec_in(vec), .done_in(dn), .req_out(iq),
        .lvl_out(il));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********************************
    // tasks
    // ********************************
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access; hold everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        r = 'x;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (wq === 1'b0)
            begin
                r = rdd;
                break;
            end
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);   // an edge passes before the next request rises
        if (n == 16)
        begin
            n_errors++;
            $display("CHECK FAILED waitrequest expected 0 seen 1");
            give_verdict();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, r);
    endtask
    task automatic ak(input logic [2:0] l, input int idle, input logic [7:0] e);
        u_core.ack(l, idle, v);
        chk("vector", {24'h0, e}, {24'h0, v});
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial
    begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 8'h00;
        wd = 32'h0;
        src = 64'h0;
        be = 4'hf;
        wdg = 1'b0;
        qs = 1'b0;
        dma = 4'h0;
        gpt = 4'h0;
        pit = 4'h0;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(IDX_MASK_HI, 32'hffffffff);
        rc(8'h48, 32'h0);
        rc(8'h43, 32'h18);
        bus(1'b1, 8'h43, 32'h3f);
        rc(8'h43, 32'h18);
        rc(8'h20, 32'h0);
        // level 5 with priorities 2, 6, 0; pairs kept unique by software
        bus(1'b1, 8'h68, 32'h2a);
        bus(1'b1, 8'h69, 32'h2e);
        bus(1'b1, 8'h6a, 32'h28);
        rc(8'h69, 32'h2e);
        // a ctrl write without lane 0 must leave the byte alone
        be <= 4'he;
        bus(1'b1, 8'h69, 32'h2a);
        be <= 4'hf;
        rc(8'h69, 32'h2e);
        bus(1'b1, IDX_MASK_HI, 32'hfffff8ff);
        bus(1'b1, IDX_MASK_LO, 32'hfffffff6);
        src <= 64'h0000_0700_0000_0008;
        @(posedge clk);
        rc(IDX_LVL_REQ, 32'h28);
        chk("level_req", 32'h28, {24'h0, lrq});
        ak(3'h5, 0, 8'h69);
        rc(IDX_ACK_LP, 32'h56);
        ak(3'h3, 3, 8'h43);
        rc(IDX_ACK_LP, 32'h38);
        // midpoint of fixed source ranks between priorities 3 and 4
        bus(1'b1, 8'h72, 32'h1b);
        bus(1'b1, 8'h73, 32'h1c);
        bus(1'b1, IDX_MASK_HI, 32'hfff3f8ff);
        src <= src | 64'h000c_0000_0000_0000;
        ak(3'h3, 0, 8'h73);
        rc(IDX_ACK_LP, 32'h34);
        bus(1'b1, IDX_MASK_HI, 32'hfffbf8ff);
        ak(3'h3, 0, 8'h43);
        // refused ack and write to the read-only byte leave it alone
        bus(1'b1, IDX_ACK_LP, 32'h7f);
        ak(3'h7, 0, 8'h18);
        rc(IDX_ACK_LP, 32'h38);
        // dead source 16 and disabled source 60 never request
        bus(1'b1, 8'h50, 32'h31);
        bus(1'b1, IDX_MASK_HI, 32'heffbf8ff);
        bus(1'b1, IDX_MASK_LO, 32'hfffefef6);
        src <= src | 64'h1000_0000_0001_0000;
        @(posedge clk);
        rc(IDX_LVL_REQ, 32'h28);
        chk("level_req", 32'h28, {24'h0, lrq});
        ak(3'h6, 0, 8'h18);
        rc(IDX_PEND_HI, 32'h100c0700);
        rc(IDX_PEND_LO, 32'h8);
        // mask-all silences every level while sources stay pending
        bus(1'b1, IDX_MASK_LO, 32'hfffefef7);
        rc(IDX_LVL_REQ, 32'h0);
        chk("level_req", 32'h0, {24'h0, lrq});
        rc(IDX_PEND_HI, 32'h100c0700);
        bus(1'b1, IDX_MASK_LO, 32'hfffefef6);
        // watchdog follows its input
        bus(1'b1, 8'h48, 32'h21);
        wdg <= 1'b1;
        ak(3'h4, 0, 8'h48);
        wdg <= 1'b0;
        ak(3'h4, 0, 8'h18);
        // sticky flags, enables and clears
        bus(1'b1, 8'h49, 32'h17);
        bus(1'b1, IDX_MASK_LO, 32'hfffefcf6);
        dma <= 4'hf;
        qs <= 1'b1;
        gpt <= 4'hf;
        pit <= 4'hf;
        @(posedge clk);
        dma <= 4'h0;
        qs <= 1'b0;
        gpt <= 4'h0;
        pit <= 4'h0;
        rc(IDX_FLAG_STAT, 32'h1fff);
        chk("irq", 32'h0, {31'h0, irq});
        ak(3'h2, 0, 8'h49);
        bus(1'b1, IDX_FLAG_EN, 32'h1fff);
        rc(IDX_FLAG_EN, 32'h1fff);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_FLAG_CLR, 32'h000f);
        rc(IDX_FLAG_STAT, 32'h1ff0);
        ak(3'h2, 0, 8'h18);
        bus(1'b1, IDX_PIT_MOD, 32'h5);
        rc(IDX_FLAG_STAT, 32'h15f0);
        bus(1'b1, IDX_FLAG_CLR, 32'h1ff0);
        rc(IDX_FLAG_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        give_verdict();
    end
endmodule // testbench
